// *** rtl/rpfm_defines.svh ***
// Constants for the radio pad function multiplexer
`ifndef RPFM_DEFINES_SVH
`define RPFM_DEFINES_SVH

`define RPFM_SEL_W      3
`define RPFM_PAD_N      15
`define RPFM_SEL_RST    3'h0

// Select codes
`define RPFM_FN_0       3'h0
`define RPFM_FN_1       3'h1
`define RPFM_FN_2       3'h2
`define RPFM_FN_3       3'h3
`define RPFM_FN_4       3'h4
`define RPFM_FN_5       3'h5
`define RPFM_FN_6       3'h6
`define RPFM_FN_7       3'h7

// Pad indices
`define RPFM_P_CTS      0
`define RPFM_P_RTS      1
`define RPFM_P_RXD      2
`define RPFM_P_TXD      3
`define RPFM_P_VDI      4
`define RPFM_P_VDO      5
`define RPFM_P_VFS      6
`define RPFM_P_VBC      7
`define RPFM_P_ADO      8
`define RPFM_P_ADI      9
`define RPFM_P_AWS      10
`define RPFM_P_ACK      11
`define RPFM_P_G1       12
`define RPFM_P_G0       13
`define RPFM_P_CRQ      14

`endif

// *** rtl/rpfm_pkg.sv ***
// Types for the radio pad function multiplexer
package rpfm_pkg;

   typedef logic [2:0] rpfm_sel_t;

   // Signals driven by the internal peripherals toward the pads
   typedef struct packed {
      logic [7:0] gpio_o;
      logic [7:0] gpio_oe;
      logic [7:0] agpio_o;
      logic [7:0] agpio_oe;
      logic       rts_n;
      logic       txd;
      logic       voice_master;
      logic       voice_sync_o;
      logic       voice_clk_o;
      logic       voice_data_o;
      logic       host_clk;
      logic       lpo_clk;
      logic       link_indicator;
      logic       i2s_master_word_select;
      logic       i2s_master_bit_clock;
      logic       i2s_master_data_out;
      logic       i2s_slave_data_out;
      logic       prio_status;
      logic       class1_bit2;
      logic       clk_12p288;
      logic       clk_request;
   } rpfm_core_out_s;

   // Signals returned from the pads to the internal peripherals
   typedef struct packed {
      logic [7:0] gpio_i;
      logic [7:0] agpio_i;
      logic       cts_n;
      logic       rxd;
      logic       voice_data_i;
      logic       voice_sync_i;
      logic       voice_clk_i;
      logic       i2s_slave_word_select;
      logic       i2s_slave_bit_clock;
      logic       i2s_data_in;
      logic       coexist_transmit_confirm;
   } rpfm_core_in_s;

endpackage

// *** rtl/rpfm_mux.sv ***
// Radio pad function multiplexer with per-pad selects
//
// Function
// - Each multiplexed pad takes its function from its own select, values 0 to 7.
// - Every pad select acts alone; one pad's setting never affects another pad.
// - Select 0 on a radio I/O pad makes it a plain general-purpose I/O, except on the UART and clock request pads.
// - Frame sync pad: 0 A-I/O 1, 1/2 voice sync, 3 host clock, 4 low-power clock, 5/7 I2S ws.
// - Data out pad: 0 A-I/O 2, 1/2 voice data, 3 link indicator, 5/7 I2S master/slave data.
// - Bit clock and audio clock pads drive the I2S master clock at 5, take slave clock at 7.
// - Word-select pad: 0 I/O 7, 1 voice sync, 3 link indicator, 5/7 I2S master/slave ws.
// - Audio data-out pad: 0 A-I/O 5, 1 voice data, 4 slave data, 5 master data, 7 status.
// - Voice frame sync is driven in master role and taken from the pad in slave role.
// - Voice bit clock is driven in master role and taken from the pad in slave role.
// - The radio activity flag is high through every local receive and transmit slot.
// - The status function presents the current priority status to the partner.
// - Clock request pad carries the clock request at 0 and A-I/O 7 at 7.
// - Host drives clear-to-send in; the device drives request-to-send out.
`timescale 1ns/100ps
`include "rpfm_defines.svh"

module rpfm_mux #(
   parameter int PAD_N = `RPFM_PAD_N
) (
   // Clock, reset, enable
   input  wire logic                         clk,
   input  wire logic                         sys_rst,
   input  wire logic                         ce,
   // Select programming
   input  wire logic [PAD_N-1:0]             sel_wr_en,
   input  wire logic [`RPFM_SEL_W-1:0]       sel_wdata,
   output logic [PAD_N-1:0][`RPFM_SEL_W-1:0] sel_reg,
   // Core side
   input  wire rpfm_pkg::rpfm_core_out_s     core_o,
   output rpfm_pkg::rpfm_core_in_s           core_i_reg,
   input  wire logic                         local_rx_slot,
   input  wire logic                         local_tx_slot,
   output logic                              radio_activity_flag_reg,
   // Pad side
   input  wire logic [PAD_N-1:0]             pad_i,
   output logic [PAD_N-1:0]                  pad_o_reg,
   output logic [PAD_N-1:0]                  pad_oe_reg
);

   ////////////////////////////////////////////////////////////////////////////
   logic [PAD_N-1:0]        pad_o_next;
   logic [PAD_N-1:0]        pad_oe_next;
   rpfm_pkg::rpfm_core_in_s core_i_next;
   wire logic               activity_next = local_rx_slot | local_tx_slot;

   // One select register per pad, each written on its own strobe
   genvar g;
   generate
      for (g = 0; g < PAD_N; g++) begin : g_sel
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               sel_reg[g] <= `RPFM_SEL_RST;
            end else if (ce && sel_wr_en[g]) begin
               sel_reg[g] <= sel_wdata;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Routing. Inputs seen on several pads are ORed; unselected ones stay 0, except cts_n, which idles high.
   always_comb begin
      pad_o_next  = '0;
      pad_oe_next = '0;
      core_i_next = '0;
      core_i_next.cts_n = 1'b1; // Active low, so idle is high

      unique case (sel_reg[`RPFM_P_CTS])
         `RPFM_FN_0: core_i_next.cts_n = pad_i[`RPFM_P_CTS];
         `RPFM_FN_7: begin
            pad_o_next[`RPFM_P_CTS]  = core_o.agpio_o[1];
            pad_oe_next[`RPFM_P_CTS] = core_o.agpio_oe[1];
            core_i_next.agpio_i[1]   = pad_i[`RPFM_P_CTS];
         end
         default: ;
      endcase

      unique case (sel_reg[`RPFM_P_RTS])
         `RPFM_FN_0: begin
            pad_o_next[`RPFM_P_RTS]  = core_o.rts_n;
            pad_oe_next[`RPFM_P_RTS] = 1'b1;
         end
         `RPFM_FN_7: begin
            pad_o_next[`RPFM_P_RTS]  = core_o.agpio_o[0];
            pad_oe_next[`RPFM_P_RTS] = core_o.agpio_oe[0];
            core_i_next.agpio_i[0]   = pad_i[`RPFM_P_RTS];
         end
         default: ;
      endcase

      unique case (sel_reg[`RPFM_P_RXD])
         `RPFM_FN_0: core_i_next.rxd = pad_i[`RPFM_P_RXD];
         `RPFM_FN_7: begin
            pad_o_next[`RPFM_P_RXD]  = core_o.gpio_o[5];
            pad_oe_next[`RPFM_P_RXD] = core_o.gpio_oe[5];
            core_i_next.gpio_i[5]    = pad_i[`RPFM_P_RXD];
         end
         default: ;
      endcase

      unique case (sel_reg[`RPFM_P_TXD])
         `RPFM_FN_0: begin
            pad_o_next[`RPFM_P_TXD]  = core_o.txd;
            pad_oe_next[`RPFM_P_TXD] = 1'b1;
         end
         `RPFM_FN_7: begin
            pad_o_next[`RPFM_P_TXD]  = core_o.gpio_o[4];
            pad_oe_next[`RPFM_P_TXD] = core_o.gpio_oe[4];
            core_i_next.gpio_i[4]    = pad_i[`RPFM_P_TXD];
         end
         default: ;
      endcase

      unique case (sel_reg[`RPFM_P_VDI])
         `RPFM_FN_0: begin
            pad_o_next[`RPFM_P_VDI]  = core_o.agpio_o[3];
            pad_oe_next[`RPFM_P_VDI] = core_o.agpio_oe[3];
            core_i_next.agpio_i[3]   = pad_i[`RPFM_P_VDI];
         end
         `RPFM_FN_1, `RPFM_FN_2: core_i_next.voice_data_i = pad_i[`RPFM_P_VDI];
         `RPFM_FN_3: begin
            pad_o_next[`RPFM_P_VDI]  = core_o.host_clk;
            pad_oe_next[`RPFM_P_VDI] = 1'b1;
         end
         `RPFM_FN_7: core_i_next.i2s_data_in = pad_i[`RPFM_P_VDI];
         default: ;
      endcase

      unique case (sel_reg[`RPFM_P_VDO])
         `RPFM_FN_0: begin
            pad_o_next[`RPFM_P_VDO]  = core_o.agpio_o[2];
            pad_oe_next[`RPFM_P_VDO] = core_o.agpio_oe[2];
            core_i_next.agpio_i[2]   = pad_i[`RPFM_P_VDO];
         end
         `RPFM_FN_1, `RPFM_FN_2: begin
            pad_o_next[`RPFM_P_VDO]  = core_o.voice_data_o;
            pad_oe_next[`RPFM_P_VDO] = 1'b1;
         end
         `RPFM_FN_3: begin
            pad_o_next[`RPFM_P_VDO]  = core_o.link_indicator;
            pad_oe_next[`RPFM_P_VDO] = 1'b1;
         end
         `RPFM_FN_5: begin
            pad_o_next[`RPFM_P_VDO]  = core_o.i2s_master_data_out;
            pad_oe_next[`RPFM_P_VDO] = 1'b1;
         end
         `RPFM_FN_7: begin
            pad_o_next[`RPFM_P_VDO]  = core_o.i2s_slave_data_out;
            pad_oe_next[`RPFM_P_VDO] = 1'b1;
         end
         default: ;
      endcase

      unique case (sel_reg[`RPFM_P_VFS])
         `RPFM_FN_0: begin
            pad_o_next[`RPFM_P_VFS]  = core_o.agpio_o[1];
            pad_oe_next[`RPFM_P_VFS] = core_o.agpio_oe[1];
            core_i_next.agpio_i[1]   = core_i_next.agpio_i[1] | pad_i[`RPFM_P_VFS];
         end
         `RPFM_FN_1, `RPFM_FN_2: begin
            pad_o_next[`RPFM_P_VFS]  = core_o.voice_sync_o;
            pad_oe_next[`RPFM_P_VFS] = core_o.voice_master;
            core_i_next.voice_sync_i = !core_o.voice_master && pad_i[`RPFM_P_VFS];
         end
         `RPFM_FN_3: begin
            pad_o_next[`RPFM_P_VFS]  = core_o.host_clk;
            pad_oe_next[`RPFM_P_VFS] = 1'b1;
         end
         `RPFM_FN_4: begin
            pad_o_next[`RPFM_P_VFS]  = core_o.lpo_clk;
            pad_oe_next[`RPFM_P_VFS] = 1'b1;
         end
         `RPFM_FN_5: begin
            pad_o_next[`RPFM_P_VFS]  = core_o.i2s_master_word_select;
            pad_oe_next[`RPFM_P_VFS] = 1'b1;
         end
         `RPFM_FN_7: core_i_next.i2s_slave_word_select = pad_i[`RPFM_P_VFS];
         default: ;
      endcase

      unique case (sel_reg[`RPFM_P_VBC])
         `RPFM_FN_0: begin
            pad_o_next[`RPFM_P_VBC]  = core_o.agpio_o[0];
            pad_oe_next[`RPFM_P_VBC] = core_o.agpio_oe[0];
            core_i_next.agpio_i[0]   = core_i_next.agpio_i[0] | pad_i[`RPFM_P_VBC];
         end
         `RPFM_FN_1, `RPFM_FN_2: begin
            pad_o_next[`RPFM_P_VBC]  = core_o.voice_clk_o;
            pad_oe_next[`RPFM_P_VBC] = core_o.voice_master;
            core_i_next.voice_clk_i  = !core_o.voice_master && pad_i[`RPFM_P_VBC];
         end
         `RPFM_FN_5: begin
            pad_o_next[`RPFM_P_VBC]  = core_o.i2s_master_bit_clock;
            pad_oe_next[`RPFM_P_VBC] = 1'b1;
         end
         `RPFM_FN_7: core_i_next.i2s_slave_bit_clock = pad_i[`RPFM_P_VBC];
         default: ;
      endcase

      unique case (sel_reg[`RPFM_P_ADO])
         `RPFM_FN_0: begin
            pad_o_next[`RPFM_P_ADO]  = core_o.agpio_o[5];
            pad_oe_next[`RPFM_P_ADO] = core_o.agpio_oe[5];
            core_i_next.agpio_i[5]   = pad_i[`RPFM_P_ADO];
         end
         `RPFM_FN_1: begin
            pad_o_next[`RPFM_P_ADO]  = core_o.voice_data_o;
            pad_oe_next[`RPFM_P_ADO] = 1'b1;
         end
         `RPFM_FN_4: begin
            pad_o_next[`RPFM_P_ADO]  = core_o.i2s_slave_data_out;
            pad_oe_next[`RPFM_P_ADO] = 1'b1;
         end
         `RPFM_FN_5: begin
            pad_o_next[`RPFM_P_ADO]  = core_o.i2s_master_data_out;
            pad_oe_next[`RPFM_P_ADO] = 1'b1;
         end
         `RPFM_FN_7: begin
            pad_o_next[`RPFM_P_ADO]  = core_o.prio_status;
            pad_oe_next[`RPFM_P_ADO] = 1'b1;
         end
         default: ;
      endcase

      unique case (sel_reg[`RPFM_P_ADI])
         `RPFM_FN_0: begin
            pad_o_next[`RPFM_P_ADI]  = core_o.agpio_o[6];
            pad_oe_next[`RPFM_P_ADI] = core_o.agpio_oe[6];
            core_i_next.agpio_i[6]   = pad_i[`RPFM_P_ADI];
         end
         `RPFM_FN_1: core_i_next.voice_data_i = core_i_next.voice_data_i | pad_i[`RPFM_P_ADI];
         `RPFM_FN_3: begin
            pad_o_next[`RPFM_P_ADI]  = core_o.host_clk;
            pad_oe_next[`RPFM_P_ADI] = 1'b1;
         end
         `RPFM_FN_4: core_i_next.i2s_data_in = core_i_next.i2s_data_in | pad_i[`RPFM_P_ADI];
         `RPFM_FN_7: core_i_next.coexist_transmit_confirm = pad_i[`RPFM_P_ADI];
         default: ;
      endcase

      unique case (sel_reg[`RPFM_P_AWS])
         `RPFM_FN_0: begin
            pad_o_next[`RPFM_P_AWS]  = core_o.gpio_o[7];
            pad_oe_next[`RPFM_P_AWS] = core_o.gpio_oe[7];
            core_i_next.gpio_i[7]    = pad_i[`RPFM_P_AWS];
         end
         `RPFM_FN_1: begin
            pad_o_next[`RPFM_P_AWS]  = core_o.voice_sync_o;
            pad_oe_next[`RPFM_P_AWS] = core_o.voice_master;
            core_i_next.voice_sync_i = core_i_next.voice_sync_i
                                       | (!core_o.voice_master && pad_i[`RPFM_P_AWS]);
         end
         `RPFM_FN_3: begin
            pad_o_next[`RPFM_P_AWS]  = core_o.link_indicator;
            pad_oe_next[`RPFM_P_AWS] = 1'b1;
         end
         `RPFM_FN_5: begin
            pad_o_next[`RPFM_P_AWS]  = core_o.i2s_master_word_select;
            pad_oe_next[`RPFM_P_AWS] = 1'b1;
         end
         `RPFM_FN_7: core_i_next.i2s_slave_word_select =
            core_i_next.i2s_slave_word_select | pad_i[`RPFM_P_AWS];
         default: ;
      endcase

      unique case (sel_reg[`RPFM_P_ACK])
         `RPFM_FN_0: begin
            pad_o_next[`RPFM_P_ACK]  = core_o.gpio_o[6];
            pad_oe_next[`RPFM_P_ACK] = core_o.gpio_oe[6];
            core_i_next.gpio_i[6]    = pad_i[`RPFM_P_ACK];
         end
         `RPFM_FN_1: begin
            pad_o_next[`RPFM_P_ACK]  = core_o.voice_clk_o;
            pad_oe_next[`RPFM_P_ACK] = core_o.voice_master;
            core_i_next.voice_clk_i  = core_i_next.voice_clk_i
                                       | (!core_o.voice_master && pad_i[`RPFM_P_ACK]);
         end
         `RPFM_FN_4: begin
            pad_o_next[`RPFM_P_ACK]  = core_o.lpo_clk;
            pad_oe_next[`RPFM_P_ACK] = 1'b1;
         end
         `RPFM_FN_5: begin
            pad_o_next[`RPFM_P_ACK]  = core_o.i2s_master_bit_clock;
            pad_oe_next[`RPFM_P_ACK] = 1'b1;
         end
         `RPFM_FN_7: core_i_next.i2s_slave_bit_clock =
            core_i_next.i2s_slave_bit_clock | pad_i[`RPFM_P_ACK];
         default: ;
      endcase

      unique case (sel_reg[`RPFM_P_G1])
         `RPFM_FN_0: begin
            pad_o_next[`RPFM_P_G1]  = core_o.gpio_o[1];
            pad_oe_next[`RPFM_P_G1] = core_o.gpio_oe[1];
            core_i_next.gpio_i[1]   = pad_i[`RPFM_P_G1];
         end
         `RPFM_FN_7: begin
            pad_o_next[`RPFM_P_G1]  = core_o.class1_bit2;
            pad_oe_next[`RPFM_P_G1] = 1'b1;
         end
         default: ;
      endcase

      unique case (sel_reg[`RPFM_P_G0])
         `RPFM_FN_0: begin
            pad_o_next[`RPFM_P_G0]  = core_o.gpio_o[0];
            pad_oe_next[`RPFM_P_G0] = core_o.gpio_oe[0];
            core_i_next.gpio_i[0]   = pad_i[`RPFM_P_G0];
         end
         `RPFM_FN_4: begin
            pad_o_next[`RPFM_P_G0]  = core_o.clk_12p288;
            pad_oe_next[`RPFM_P_G0] = 1'b1;
         end
         default: ;
      endcase

      unique case (sel_reg[`RPFM_P_CRQ])
         `RPFM_FN_0: begin
            pad_o_next[`RPFM_P_CRQ]  = core_o.clk_request;
            pad_oe_next[`RPFM_P_CRQ] = 1'b1;
         end
         `RPFM_FN_7: begin
            pad_o_next[`RPFM_P_CRQ]  = core_o.agpio_o[7];
            pad_oe_next[`RPFM_P_CRQ] = core_o.agpio_oe[7];
            core_i_next.agpio_i[7]   = pad_i[`RPFM_P_CRQ];
         end
         default: ;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs cost one cycle of latency but keep pad timing clean
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pad_o_reg               <= '0;
         pad_oe_reg              <= '0;
         core_i_reg              <= '0;
         radio_activity_flag_reg <= 1'b0;
      end else if (ce) begin
         pad_o_reg               <= pad_o_next;
         pad_oe_reg              <= pad_oe_next;
         core_i_reg              <= core_i_next;
         radio_activity_flag_reg <= activity_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_sel(int p, logic [2:0] v);
      ce && sel_reg[p] == v;
   endsequence

   sel_write_a: assert property (@(posedge clk) disable iff (sys_rst)
      ce && sel_wr_en[`RPFM_P_VDO] |=> sel_reg[`RPFM_P_VDO] == $past(sel_wdata))
      else $error("select write lost");
   sel_indep_a: assert property (@(posedge clk) disable iff (sys_rst)
      ce && !sel_wr_en[`RPFM_P_G1] |=> $stable(sel_reg[`RPFM_P_G1]))
      else $error("select changed without its strobe");
   ce_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      !ce |=> $stable(sel_reg) && $stable(pad_o_reg) && $stable(pad_oe_reg)
      && $stable(core_i_reg) && $stable(radio_activity_flag_reg))
      else $error("state moved with enable low");
   unused_off_a: assert property (@(posedge clk) disable iff (sys_rst)
      s_sel(`RPFM_P_CTS, `RPFM_FN_3) |=> !pad_oe_reg[`RPFM_P_CTS]
      && core_i_reg.cts_n)
      else $error("unused select drives pad");
   sync_role_a: assert property (@(posedge clk) disable iff (sys_rst)
      s_sel(`RPFM_P_VFS, `RPFM_FN_1) |=> pad_oe_reg[`RPFM_P_VFS] == $past(core_o.voice_master))
      else $error("frame sync direction wrong");
   clk_slave_a: assert property (@(posedge clk) disable iff (sys_rst)
      s_sel(`RPFM_P_VBC, `RPFM_FN_2) ##0 !core_o.voice_master ##0 pad_i[`RPFM_P_VBC]
      |=> !pad_oe_reg[`RPFM_P_VBC] && core_i_reg.voice_clk_i)
      else $error("slave bit clock not taken");
   activity_a: assert property (@(posedge clk) disable iff (sys_rst)
      ce |=> radio_activity_flag_reg == $past(activity_next))
      else $error("activity flag not following slots");
   status_out_a: assert property (@(posedge clk) disable iff (sys_rst)
      s_sel(`RPFM_P_ADO, `RPFM_FN_7) |=> pad_oe_reg[`RPFM_P_ADO]
      && pad_o_reg[`RPFM_P_ADO] == $past(core_o.prio_status))
      else $error("status not on pad");
   clk_req_a: assert property (@(posedge clk) disable iff (sys_rst)
      s_sel(`RPFM_P_CRQ, `RPFM_FN_0) |=> pad_oe_reg[`RPFM_P_CRQ]
      && pad_o_reg[`RPFM_P_CRQ] == $past(core_o.clk_request))
      else $error("clock request not on pad");
   rts_out_a: assert property (@(posedge clk) disable iff (sys_rst)
      s_sel(`RPFM_P_RTS, `RPFM_FN_0) |=> pad_oe_reg[`RPFM_P_RTS]
      && pad_o_reg[`RPFM_P_RTS] == $past(core_o.rts_n))
      else $error("request to send not driven");
   confirm_in_a: assert property (@(posedge clk) disable iff (sys_rst)
      s_sel(`RPFM_P_ADI, `RPFM_FN_7) |=> !pad_oe_reg[`RPFM_P_ADI]
      && core_i_reg.coexist_transmit_confirm == $past(pad_i[`RPFM_P_ADI]))
      else $error("transmit confirm not taken");

endmodule

// *** test/rpfm_peer.sv ***
// Board-side peer model: codec, host UART and coexistence partner
`timescale 1ns/100ps

module rpfm_peer (
   // Device pad drivers
   input  wire logic [14:0] pad_o,
   input  wire logic [14:0] pad_oe,
   // Levels the peer puts on pads the device leaves undriven
   input  wire logic [14:0] ext_level,
   // Resolved pad levels seen by the device
   output logic      [14:0] pad_i
);
   // Device wins where it drives, so a wrong enable shows up as a lost peer level
   assign pad_i = (pad_oe & pad_o) | (~pad_oe & ext_level);
endmodule

// *** test/rpfm_mux_bench.sv ***
// Self-checking bench for the radio pad function multiplexer
`timescale 1ns/100ps
`include "rpfm_defines.svh"

module rpfm_mux_bench;
   typedef struct {int pad; int sel; int src; int oe;} rpfm_row_s;
   // Source bit N means none; oe I marks a row that checks a pad input
   localparam int N    = 63;
   localparam int I    = 99;
   localparam int ROWS = 63;
   logic                       clk;
   logic                       sys_rst;
   logic                       ce;
   logic [14:0]                sel_wr_en;
   logic [2:0]                 sel_wdata;
   logic [14:0][2:0]           sel_reg;
   logic [14:0][2:0]           exp_sel;
   logic [48:0]                core_bits;
   rpfm_pkg::rpfm_core_in_s    core_i_reg;
   logic                       local_rx_slot;
   logic                       local_tx_slot;
   logic                       radio_activity_flag_reg;
   logic [14:0]                pad_i;
   logic [14:0]                pad_o_reg;
   logic [14:0]                pad_oe_reg;
   logic [14:0]                ext_level;
   int                         miscompares = 0;
   int                         check_count = 0;
   // Bit positions below follow the packed layout of the core structs
   rpfm_row_s rows [ROWS] = '{
      '{6,0,26,18}, '{6,1,13,14}, '{6,2,13,14}, '{6,3,10,N}, '{6,4,9,N}, '{6,5,7,N},
      '{5,0,27,19}, '{5,1,11,N}, '{5,2,11,N}, '{5,3,8,N}, '{5,5,5,N}, '{5,7,4,N},
      '{7,1,12,14}, '{7,5,6,N}, '{11,5,6,N}, '{11,4,9,N},
      '{10,0,48,40}, '{10,1,13,14}, '{10,3,8,N}, '{10,5,7,N},
      '{8,0,30,22}, '{8,1,11,N}, '{8,4,4,N}, '{8,5,5,N}, '{8,7,3,N},
      '{4,0,28,20}, '{4,3,10,N}, '{9,0,31,23}, '{9,3,10,N}, '{11,0,47,39},
      '{11,1,12,14}, '{7,0,25,17}, '{12,0,42,34}, '{0,7,26,18},
      '{1,7,25,17}, '{2,7,46,38}, '{3,7,45,37},
      '{14,0,0,N}, '{14,7,32,24}, '{1,0,16,N}, '{3,0,15,N},
      '{12,7,2,N}, '{13,4,1,N}, '{13,0,41,33},
      '{6,6,N,0}, '{0,3,N,0}, '{4,4,N,0},
      '{6,1,5,I}, '{7,1,4,I}, '{6,7,3,I}, '{10,7,3,I}, '{7,7,2,I},
      '{9,7,0,I}, '{4,1,6,I}, '{2,0,7,I}, '{0,0,8,I}, '{13,0,17,I},
      '{4,7,1,I}, '{9,4,1,I}, '{9,1,6,I},
      '{7,2,4,I}, '{11,7,2,I}, '{0,7,10,I}
   };

////////////////////////////////////////////////////////////////////////////////
   rpfm_mux rpfm_mux_i (
      .clk                     (clk),
      .sys_rst                 (sys_rst),
      .ce                      (ce),
      .sel_wr_en               (sel_wr_en),
      .sel_wdata               (sel_wdata),
      .sel_reg                 (sel_reg),
      .core_o                  (rpfm_pkg::rpfm_core_out_s'(core_bits)),
      .core_i_reg              (core_i_reg),
      .local_rx_slot           (local_rx_slot),
      .local_tx_slot           (local_tx_slot),
      .radio_activity_flag_reg (radio_activity_flag_reg),
      .pad_i                   (pad_i),
      .pad_o_reg               (pad_o_reg),
      .pad_oe_reg              (pad_oe_reg)
   );

   rpfm_peer rpfm_peer_i (
      .pad_o     (pad_o_reg),
      .pad_oe    (pad_oe_reg),
      .ext_level (ext_level),
      .pad_i     (pad_i)
   );

////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [48:0] seen, input logic [48:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Outputs are read at the falling edge, clear of the register updates
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic wr_sel(input int pad, input int sel);
      @(posedge clk);
      sel_wr_en <= 15'h1 << pad;
      sel_wdata <= 3'(sel);
      exp_sel[pad] = 3'(sel);
      @(posedge clk);
      sel_wr_en <= 15'h0;
   endtask

   task automatic look(input rpfm_row_s r, input logic v);
      if (r.oe == I) chk("core_in", 49'(core_i_reg[r.src]), 49'(v));
      else if (r.src == N) chk("pad_oe", 49'(pad_oe_reg[r.pad]), 49'(0));
      else begin
         chk("pad_o", 49'(pad_o_reg[r.pad]), 49'(v));
         chk("pad_oe", 49'(pad_oe_reg[r.pad]), 49'(1));
      end
   endtask

   task automatic stop_test();
      if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Whole run is a few hundred cycles; this only cuts a hang
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      stop_test();
   end

   initial begin
      rpfm_row_s   r;
      logic [48:0] src_m;
      sys_rst = 1'b1;
      ce = 1'b1;
      sel_wr_en = 15'h0;
      sel_wdata = 3'h0;
      exp_sel = '0;
      core_bits = '0;
      local_rx_slot = 1'b0;
      local_tx_slot = 1'b0;
      ext_level = 15'h0;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      settle(2);
      chk("sel", 49'(sel_reg), 49'(0));
      chk("rts_oe", 49'(pad_oe_reg[`RPFM_P_RTS]), 49'(1));
      foreach (rows[k]) begin
         r = rows[k];
         wr_sel(r.pad, r.sel);
         src_m = 49'h1 << r.src;
         core_bits <= (r.oe == I) ? '0 : (r.src == N) ? '1 : src_m | (49'h1 << r.oe);
         ext_level <= (r.oe == I) ? 15'h1 << r.pad : 15'h0;
         settle(2);
         chk("sel", 49'(sel_reg), 49'(exp_sel));
         look(r, 1'b1);
         @(posedge clk);
         core_bits <= core_bits & ~src_m;
         ext_level <= 15'h0;
         settle(2);
         look(r, 1'b0);
      end
      for (int a = 0; a < 4; a++) begin
         @(posedge clk);
         local_rx_slot <= a[0];
         local_tx_slot <= a[1];
         settle(2);
         chk("activity", 49'(radio_activity_flag_reg), 49'(a[0] | a[1]));
      end
      // Enable low must freeze selects and pads while strobes and sources move
      @(posedge clk);
      ce <= 1'b0;
      sel_wr_en <= 15'h1 << `RPFM_P_RTS;
      sel_wdata <= 3'h7;
      core_bits <= 49'h1 << 16;
      settle(2);
      chk("ce_sel", 49'(sel_reg), 49'(exp_sel));
      chk("ce_rts", 49'(pad_o_reg[`RPFM_P_RTS]), 49'(0));
      @(posedge clk);
      ce <= 1'b1;
      sel_wr_en <= 15'h0;
      settle(2);
      chk("ce_rts", 49'(pad_o_reg[`RPFM_P_RTS]), 49'(1));
      // Reset in mid-run, then release it and see the default functions return
      @(posedge clk);
      sys_rst <= 1'b1;
      settle(1);
      chk("sel", 49'(sel_reg), 49'(0));
      chk("rst_oe", 49'(pad_oe_reg), 49'(0));
      @(posedge clk);
      sys_rst <= 1'b0;
      settle(1);
      chk("rts_oe", 49'(pad_oe_reg[`RPFM_P_RTS]), 49'(1));
      chk("rts_o", 49'(pad_o_reg[`RPFM_P_RTS]), 49'(1));
      chk("sel", 49'(sel_reg), 49'(0));
      stop_test();
   end
endmodule
